// ### hw/ntvmsi_cap.sv
// MSI capability block for the virtual side of a non-transparent port
//
// The Avalon-MM slave port is this design's own decision.
module ntvmsi_cap (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ntvmsi_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [ntvmsi_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [ntvmsi_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cfg_load,
  input wire ntvmsi_pkg::ntvmsi_cfg_s cfg_in,
  input wire ntvmsi_pkg::ntvmsi_evt_s evt_in,
  input wire logic [ntvmsi_pkg::NCAT-1:0] cat_clear,
  output logic msi_req,
  output ntvmsi_pkg::ntvmsi_msg_s msi_msg,
  input wire logic msi_ack,
  output logic intx_enable,
  output logic legacy_interrupt_out_n
);

  ntvmsi_pkg::ntvmsi_state_s st_q;
  ntvmsi_pkg::ntvmsi_state_s st_d;

  // Allocation in effect, clamped to the advertised capability
  function automatic logic [ntvmsi_pkg::ALLOC_W-1:0] eff_alloc(
    input logic [ntvmsi_pkg::ALLOC_W-1:0] mme,
    input logic [ntvmsi_pkg::ALLOC_W-1:0] mmc
  );
    logic [ntvmsi_pkg::ALLOC_W-1:0] cap;
    cap = (mmc > ntvmsi_pkg::ALLOC_EIGHT) ? ntvmsi_pkg::ALLOC_EIGHT : mmc;
    return (mme > cap) ? cap : mme;
  endfunction

  // Vector that carries a category
  function automatic logic [ntvmsi_pkg::VEC_W-1:0] cat_vector(
    input int cat,
    input logic [ntvmsi_pkg::ALLOC_W-1:0] eff
  );
    logic [ntvmsi_pkg::VEC_W-1:0] v;
    if (eff >= ntvmsi_pkg::ALLOC_FOUR) begin
      v = ntvmsi_pkg::VEC_W'(cat);
    end else if (eff == ntvmsi_pkg::ALLOC_TWO) begin
      v = (cat == ntvmsi_pkg::CAT_LINK) ? ntvmsi_pkg::VEC_LINK_TWO : ntvmsi_pkg::VEC_SHARED;
    end else begin
      v = ntvmsi_pkg::VEC_SHARED;
    end
    return v;
  endfunction

  // Per-vector view of the category pending bits
  function automatic logic [ntvmsi_pkg::NCAT-1:0] vec_view(
    input logic [ntvmsi_pkg::NCAT-1:0] pend,
    input logic [ntvmsi_pkg::ALLOC_W-1:0] eff
  );
    logic [ntvmsi_pkg::NCAT-1:0] v;
    v = '0;
    for (int c = 0; c < ntvmsi_pkg::NCAT; c++) begin
      v[cat_vector(c, eff)] = v[cat_vector(c, eff)] | pend[c];
    end
    return v;
  endfunction

  // Mask and status bits that exist for an allocation
  function automatic logic [ntvmsi_pkg::NCAT-1:0] bits_exist(input logic [ntvmsi_pkg::ALLOC_W-1:0] eff);
    logic [ntvmsi_pkg::NCAT-1:0] e;
    if (eff >= ntvmsi_pkg::ALLOC_FOUR) begin
      e = ntvmsi_pkg::EXIST_FOUR;
    end else if (eff == ntvmsi_pkg::ALLOC_TWO) begin
      e = ntvmsi_pkg::EXIST_TWO;
    end else begin
      e = ntvmsi_pkg::EXIST_ONE;
    end
    return e;
  endfunction

  // Register select with 32-bit relocation
  function automatic ntvmsi_pkg::ntvmsi_sel_e decode(
    input logic [ntvmsi_pkg::ADDR_W-1:0] a,
    input logic a64
  );
    ntvmsi_pkg::ntvmsi_sel_e s;
    s = ntvmsi_pkg::NTVMSI_SEL_NONE;
    if (a == ntvmsi_pkg::OFF_CTRL) begin
      s = ntvmsi_pkg::NTVMSI_SEL_CTRL;
    end else if (a == ntvmsi_pkg::OFF_ADDR_LO) begin
      s = ntvmsi_pkg::NTVMSI_SEL_ALO;
    end else if (a64) begin
      if (a == ntvmsi_pkg::OFF_ADDR_HI) begin
        s = ntvmsi_pkg::NTVMSI_SEL_AHI;
      end else if (a == ntvmsi_pkg::OFF_DATA_64) begin
        s = ntvmsi_pkg::NTVMSI_SEL_DATA;
      end else if (a == ntvmsi_pkg::OFF_MASK_64) begin
        s = ntvmsi_pkg::NTVMSI_SEL_MASK;
      end else if (a == ntvmsi_pkg::OFF_STAT_64) begin
        s = ntvmsi_pkg::NTVMSI_SEL_STAT;
      end
    end else begin
      if (a == ntvmsi_pkg::OFF_DATA_32) begin
        s = ntvmsi_pkg::NTVMSI_SEL_DATA;
      end else if (a == ntvmsi_pkg::OFF_MASK_32) begin
        s = ntvmsi_pkg::NTVMSI_SEL_MASK;
      end else if (a == ntvmsi_pkg::OFF_STAT_32) begin
        s = ntvmsi_pkg::NTVMSI_SEL_STAT;
      end
    end
    return s;
  endfunction

  // Byte-enable merge of a write into an old word
  function automatic logic [ntvmsi_pkg::DATA_W-1:0] be_merge(
    input logic [ntvmsi_pkg::DATA_W-1:0] old,
    input logic [ntvmsi_pkg::DATA_W-1:0] wd,
    input logic [3:0] be
  );
    logic [ntvmsi_pkg::DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Message data with the vector number in the low bits owned by the device
  function automatic logic [ntvmsi_pkg::DATA_W-1:0] msg_data(
    input logic [ntvmsi_pkg::MSG_DATA_W-1:0] base,
    input logic [ntvmsi_pkg::VEC_W-1:0] vec,
    input logic [ntvmsi_pkg::ALLOC_W-1:0] eff
  );
    logic [ntvmsi_pkg::DATA_W-1:0] d;
    int nbits;
    logic [ntvmsi_pkg::DBITS_EIGHT-1:0] vnum;
    d = '0;
    d[ntvmsi_pkg::MSG_DATA_W-1:0] = base;
    nbits = 0;
    if (eff == ntvmsi_pkg::ALLOC_TWO) begin
      nbits = ntvmsi_pkg::DBITS_TWO;
    end else if (eff == ntvmsi_pkg::ALLOC_FOUR) begin
      nbits = ntvmsi_pkg::DBITS_FOUR;
    end else if (eff == ntvmsi_pkg::ALLOC_EIGHT) begin
      nbits = ntvmsi_pkg::DBITS_EIGHT;
    end
    // Top data bit stays 0 under eight: vectors 4 to 7 are never sent
    vnum = {1'b0, vec};
    for (int i = 0; i < ntvmsi_pkg::DBITS_EIGHT; i++) begin
      if (i < nbits) begin
        d[i] = vnum[i];
      end
    end
    return d;
  endfunction

  // Lowest numbered ready vector
  function automatic logic [ntvmsi_pkg::VEC_W-1:0] lowest_vec(input logic [ntvmsi_pkg::NCAT-1:0] rv);
    logic [ntvmsi_pkg::VEC_W-1:0] p;
    p = '0;
    for (int v = ntvmsi_pkg::NCAT - 1; v >= 0; v--) begin
      if (rv[v]) begin
        p = ntvmsi_pkg::VEC_W'(v);
      end
    end
    return p;
  endfunction

  // Categories carried by one vector
  function automatic logic [ntvmsi_pkg::NCAT-1:0] vec_cats(
    input logic [ntvmsi_pkg::VEC_W-1:0] vec,
    input logic [ntvmsi_pkg::ALLOC_W-1:0] eff
  );
    logic [ntvmsi_pkg::NCAT-1:0] m;
    m = '0;
    for (int c = 0; c < ntvmsi_pkg::NCAT; c++) begin
      m[c] = (cat_vector(c, eff) == vec);
    end
    return m;
  endfunction

  // Control word as read, reserved bits zero
  function automatic logic [ntvmsi_pkg::DATA_W-1:0] ctrl_word(input ntvmsi_pkg::ntvmsi_state_s s);
    logic [ntvmsi_pkg::DATA_W-1:0] w;
    w = '0;
    w[ntvmsi_pkg::CAP_ID_LSB +: 8] = s.cfg.cap_id;
    w[ntvmsi_pkg::NEXT_PTR_LSB +: 8] = s.cfg.next_ptr;
    w[ntvmsi_pkg::EN_BIT] = s.en;
    w[ntvmsi_pkg::MMC_LSB +: ntvmsi_pkg::ALLOC_W] = s.cfg.mmc;
    w[ntvmsi_pkg::MME_LSB +: ntvmsi_pkg::ALLOC_W] = s.mme;
    w[ntvmsi_pkg::A64_BIT] = s.cfg.addr64;
    w[ntvmsi_pkg::PVM_BIT] = s.cfg.pvm;
    return w;
  endfunction

  // Message address, upper half zero without 64-bit addressing
  function automatic logic [2*ntvmsi_pkg::DATA_W-1:0] msg_addr(input ntvmsi_pkg::ntvmsi_state_s s);
    logic [2*ntvmsi_pkg::DATA_W-1:0] a;
    a = {{ntvmsi_pkg::DATA_W{1'b0}}, s.addr_lo};
    if (s.cfg.addr64) begin
      a[2*ntvmsi_pkg::DATA_W-1:ntvmsi_pkg::DATA_W] = s.addr_hi;
    end
    return a;
  endfunction

  logic [ntvmsi_pkg::ALLOC_W-1:0] eff;
  logic [ntvmsi_pkg::NCAT-1:0] exist;
  logic [ntvmsi_pkg::NCAT-1:0] mask_eff;
  logic [ntvmsi_pkg::NCAT-1:0] vpend;
  logic [ntvmsi_pkg::NCAT-1:0] ready_vec;
  logic [ntvmsi_pkg::NCAT-1:0] pend_set;
  logic [ntvmsi_pkg::NCAT-1:0] pend_clr;
  logic [ntvmsi_pkg::VEC_W-1:0] pick;
  logic [ntvmsi_pkg::DATA_W-1:0] merged;
  logic [ntvmsi_pkg::DATA_W-1:0] rd;
  ntvmsi_pkg::ntvmsi_sel_e sel;
  logic accept;
  logic first;

  always_comb begin
    st_d = st_q;
    eff = eff_alloc(st_q.mme, st_q.cfg.mmc);
    // No mask or status bits without per-vector masking
    exist = st_q.cfg.pvm ? bits_exist(eff) : '0;
    mask_eff = st_q.mask & exist;
    vpend = vec_view(st_q.pend, eff);
    ready_vec = vpend & ~mask_eff;
    sel = decode(avs_address, st_q.cfg.addr64);
    first = (avs_read | avs_write) & st_q.waitreq;
    accept = (avs_read | avs_write) & ~st_q.waitreq;
    pend_clr = cat_clear;
    pick = '0;

    // Bus: wait one cycle, answer on the second
    st_d.waitreq = ~first;

    // Read view, reserved bits zero
    rd = '0;
    case (sel)
      ntvmsi_pkg::NTVMSI_SEL_CTRL: begin
        rd = ctrl_word(st_q);
      end
      ntvmsi_pkg::NTVMSI_SEL_ALO: begin
        rd = st_q.addr_lo;
      end
      ntvmsi_pkg::NTVMSI_SEL_AHI: begin
        rd = st_q.addr_hi;
      end
      ntvmsi_pkg::NTVMSI_SEL_DATA: begin
        rd[ntvmsi_pkg::MSG_DATA_W-1:0] = st_q.data;
      end
      ntvmsi_pkg::NTVMSI_SEL_MASK: begin
        rd[ntvmsi_pkg::NCAT-1:0] = mask_eff;
      end
      ntvmsi_pkg::NTVMSI_SEL_STAT: begin
        rd[ntvmsi_pkg::NCAT-1:0] = vpend & exist;
      end
      default: begin
        rd = '0;
      end
    endcase
    // Write merge starts from the read view of the same word
    merged = be_merge(rd, avs_writedata, avs_byteenable);
    if (first & avs_read) begin
      st_d.rdata = rd;
    end

    // Writes take effect on the answering edge
    if (accept & avs_write) begin
      case (sel)
        ntvmsi_pkg::NTVMSI_SEL_CTRL: begin
          if (avs_byteenable[ntvmsi_pkg::CTRL_HI_BYTE]) begin
            st_d.en = avs_writedata[ntvmsi_pkg::EN_BIT];
            st_d.mme = avs_writedata[ntvmsi_pkg::MME_LSB +: ntvmsi_pkg::ALLOC_W];
          end
        end
        ntvmsi_pkg::NTVMSI_SEL_ALO: begin
          st_d.addr_lo = merged;
          st_d.addr_lo[ntvmsi_pkg::ADDR_LO_ZERO_W-1:0] = '0;
        end
        ntvmsi_pkg::NTVMSI_SEL_AHI: begin
          st_d.addr_hi = merged;
        end
        ntvmsi_pkg::NTVMSI_SEL_DATA: begin
          st_d.data = merged[ntvmsi_pkg::MSG_DATA_W-1:0];
        end
        ntvmsi_pkg::NTVMSI_SEL_MASK: begin
          if (avs_byteenable[ntvmsi_pkg::MASK_BYTE]) begin
            st_d.mask = (st_q.mask & ~exist) | (avs_writedata[ntvmsi_pkg::NCAT-1:0] & exist);
          end
        end
        default: begin
          st_d.rdata = st_q.rdata;
        end
      endcase
    end

    if (cfg_load) begin
      st_d.cfg = cfg_in;
    end

    // Event sorting into categories
    pend_set = '0;
    pend_set[ntvmsi_pkg::CAT_PM] = evt_in.pm;
    pend_set[ntvmsi_pkg::CAT_LINK] = |evt_in.link;
    pend_set[ntvmsi_pkg::CAT_GPIO] = evt_in.gpio;
    pend_set[ntvmsi_pkg::CAT_DB] = evt_in.doorbell;

    // Message issue, lowest ready vector first
    case (st_q.send)
      ntvmsi_pkg::NTVMSI_IDLE: begin
        if (st_q.en && (|ready_vec)) begin
          pick = lowest_vec(ready_vec);
          pend_clr = pend_clr | vec_cats(pick, eff);
          st_d.msg.addr = msg_addr(st_q);
          st_d.msg.data = msg_data(st_q.data, pick, eff);
          st_d.msg.vector = pick;
          st_d.msi_req = 1'b1;
          st_d.send = ntvmsi_pkg::NTVMSI_SEND;
        end
      end
      ntvmsi_pkg::NTVMSI_SEND: begin
        if (msi_ack) begin
          st_d.msi_req = 1'b0;
          st_d.send = ntvmsi_pkg::NTVMSI_IDLE;
        end
      end
      default: begin
        st_d.msi_req = 1'b0;
        st_d.send = ntvmsi_pkg::NTVMSI_IDLE;
      end
    endcase

    // New events win over clears in the same cycle
    st_d.pend = (st_q.pend & ~pend_clr) | pend_set;

    // Legacy path only while messages are disabled
    st_d.intx_en = ~st_q.en;
    st_d.legacy_n = ~(~st_q.en & (|st_q.pend));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ntvmsi_pkg::STATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = st_q.waitreq;
  assign msi_req = st_q.msi_req;
  assign msi_msg = st_q.msg;
  assign intx_enable = st_q.intx_en;
  assign legacy_interrupt_out_n = st_q.legacy_n;

endmodule

// ### pkg/ntvmsi_pkg.sv
// Package: MSI capability offsets, fields, defaults, carrier and state types
package ntvmsi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCAT = 4;
  localparam int VEC_W = 2;
  localparam int ALLOC_W = 3;
  localparam int MSG_DATA_W = 16;
  localparam int MASK_BYTE = 0;
  localparam int LINK_SRC_N = 4;

  // Byte offsets, 64-bit layout and relocated 32-bit layout
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LO = 8'h4c;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HI = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_DATA_64 = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_MASK_64 = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_STAT_64 = 8'h5c;
  localparam logic [ADDR_W-1:0] OFF_DATA_32 = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_MASK_32 = 8'h54;
  localparam logic [ADDR_W-1:0] OFF_STAT_32 = 8'h58;
  localparam logic [ADDR_W-1:0] OFF_RSVD = 8'h60;

  // Control word field positions
  localparam int CAP_ID_LSB = 0;
  localparam int NEXT_PTR_LSB = 8;
  localparam int EN_BIT = 16;
  localparam int MMC_LSB = 17;
  localparam int MME_LSB = 20;
  localparam int A64_BIT = 23;
  localparam int PVM_BIT = 24;
  localparam int CTRL_HI_BYTE = 2;
  localparam int ADDR_LO_ZERO_W = 2;

  // Allocation codes
  localparam logic [ALLOC_W-1:0] ALLOC_ONE = 3'h0;
  localparam logic [ALLOC_W-1:0] ALLOC_TWO = 3'h1;
  localparam logic [ALLOC_W-1:0] ALLOC_FOUR = 3'h2;
  localparam logic [ALLOC_W-1:0] ALLOC_EIGHT = 3'h3;

  // Reset values
  localparam logic [7:0] CAP_ID_RST = 8'h05;
  localparam logic [7:0] NEXT_PTR_RST = 8'h68;
  localparam logic [ALLOC_W-1:0] MMC_RST = ALLOC_EIGHT;
  localparam logic [ALLOC_W-1:0] MME_RST = ALLOC_ONE;
  localparam logic EN_RST = 1'b0;
  localparam logic A64_RST = 1'b1;
  localparam logic PVM_RST = 1'b1;

  // Category positions in mask and status words
  localparam int CAT_PM = 0;
  localparam int CAT_LINK = 1;
  localparam int CAT_GPIO = 2;
  localparam int CAT_DB = 3;
  localparam logic [VEC_W-1:0] VEC_SHARED = 2'h0;
  localparam logic [VEC_W-1:0] VEC_LINK_TWO = 2'h1;
  localparam logic [NCAT-1:0] EXIST_ONE = 4'h1;
  localparam logic [NCAT-1:0] EXIST_TWO = 4'h3;
  localparam logic [NCAT-1:0] EXIST_FOUR = 4'hf;
  localparam int DBITS_TWO = 1;
  localparam int DBITS_FOUR = 2;
  localparam int DBITS_EIGHT = 3;

  typedef struct packed {
    logic [7:0] cap_id;
    logic [7:0] next_ptr;
    logic [ALLOC_W-1:0] mmc;
    logic addr64;
    logic pvm;
  } ntvmsi_cfg_s;

  typedef struct packed {
    logic pm;
    logic [LINK_SRC_N-1:0] link;
    logic gpio;
    logic doorbell;
  } ntvmsi_evt_s;

  typedef struct packed {
    logic [63:0] addr;
    logic [DATA_W-1:0] data;
    logic [VEC_W-1:0] vector;
  } ntvmsi_msg_s;

  typedef enum logic [1:0] {
    NTVMSI_IDLE = 2'b01,
    NTVMSI_SEND = 2'b10
  } ntvmsi_send_e;

  typedef enum logic [6:0] {
    NTVMSI_SEL_NONE = 7'b0000001,
    NTVMSI_SEL_CTRL = 7'b0000010,
    NTVMSI_SEL_ALO = 7'b0000100,
    NTVMSI_SEL_AHI = 7'b0001000,
    NTVMSI_SEL_DATA = 7'b0010000,
    NTVMSI_SEL_MASK = 7'b0100000,
    NTVMSI_SEL_STAT = 7'b1000000
  } ntvmsi_sel_e;

  typedef struct packed {
    ntvmsi_cfg_s cfg;
    logic en;
    logic [ALLOC_W-1:0] mme;
    logic [DATA_W-1:0] addr_lo;
    logic [DATA_W-1:0] addr_hi;
    logic [MSG_DATA_W-1:0] data;
    logic [NCAT-1:0] mask;
    logic [NCAT-1:0] pend;
    ntvmsi_send_e send;
    logic msi_req;
    ntvmsi_msg_s msg;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic legacy_n;
    logic intx_en;
  } ntvmsi_state_s;

  localparam ntvmsi_state_s STATE_RST = '{
    cfg: '{cap_id: CAP_ID_RST, next_ptr: NEXT_PTR_RST, mmc: MMC_RST, addr64: A64_RST, pvm: PVM_RST},
    en: EN_RST,
    mme: MME_RST,
    addr_lo: '0,
    addr_hi: '0,
    data: '0,
    mask: '0,
    pend: '0,
    send: NTVMSI_IDLE,
    msi_req: 1'b0,
    msg: '0,
    waitreq: 1'b1,
    rdata: '0,
    legacy_n: 1'b1,
    intx_en: 1'b1
  };
endpackage

// ### tb/ntvmsi_cap_chk.sv
// Port checker for the MSI capability block
module ntvmsi_cap_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic msi_req,
  input wire ntvmsi_pkg::ntvmsi_msg_s msi_msg,
  input wire logic msi_ack,
  input wire logic intx_enable,
  input wire logic legacy_interrupt_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer too long");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("bus answer without request");
  rsvd_zero_a: assert property (avs_read && avs_waitrequest && avs_address == 8'h60 |=> avs_readdata == '0)
    else $error("reserved word not zero");
  ctrl_rsvd_a: assert property (avs_read && avs_waitrequest && avs_address == 8'h48 |=> avs_readdata[31:25] == 7'h0)
    else $error("control top bits not zero");
  msg_hold_a: assert property (msi_req && !msi_ack |=> msi_req && $stable(msi_msg))
    else $error("message changed before acknowledge");
  msg_drop_a: assert property (msi_req && msi_ack |=> !msi_req)
    else $error("message kept after acknowledge");
  legacy_quiet_a: assert property (!intx_enable |-> legacy_interrupt_out_n)
    else $error("legacy pin low while messages enabled");
  send_enabled_a: assert property ($rose(msi_req) |-> !intx_enable)
    else $error("message sent while disabled");
endmodule
bind ntvmsi_cap ntvmsi_cap_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .msi_req(msi_req),
  .msi_msg(msi_msg), .msi_ack(msi_ack), .intx_enable(intx_enable), .legacy_interrupt_out_n(legacy_interrupt_out_n));

// ### tb/ntvmsi_host.sv
// Behavioural host that accepts message writes after a chosen delay
module ntvmsi_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic msi_req,
  input wire ntvmsi_pkg::ntvmsi_msg_s msi_msg,
  input wire logic [3:0] delay,
  output logic msi_ack,
  output int rx_count,
  output ntvmsi_pkg::ntvmsi_msg_s rx_msg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_ack <= 1'b0;
      wait_q <= 4'h0;
      rx_count <= 0;
      rx_msg <= '0;
    end else if (msi_ack) begin
      // Message taken at the edge the acknowledge is seen
      msi_ack <= 1'b0;
      wait_q <= 4'h0;
      rx_count <= rx_count + 1;
      rx_msg <= msi_msg;
    end else if (msi_req) begin
      msi_ack <= (wait_q >= delay);
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// ### tb/test_ntvmsi_cap.sv
// Testbench for the MSI capability block with a behavioural host
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module test_ntvmsi_cap;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, cfg_load;
  logic msi_req, msi_ack, intx_enable, legacy_interrupt_out_n;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, rd, m_lo, m_hi;
  logic [3:0] avs_byteenable, cat_clear, delay, m_mask;
  logic [15:0] m_base;
  ntvmsi_pkg::ntvmsi_cfg_s cfg_in;
  ntvmsi_pkg::ntvmsi_evt_s evt_in;
  ntvmsi_pkg::ntvmsi_msg_s msi_msg, rx_msg;
  int rx_count, num_errors, checks_done, m_mmc, m_a64, eff, n;
  int codes[5] = '{7, 3, 2, 1, 0};
  ntvmsi_cap DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cfg_load(cfg_load), .cfg_in(cfg_in), .evt_in(evt_in), .cat_clear(cat_clear),
    .msi_req(msi_req), .msi_msg(msi_msg), .msi_ack(msi_ack), .intx_enable(intx_enable),
    .legacy_interrupt_out_n(legacy_interrupt_out_n));
  ntvmsi_host host (.clk(clk), .rst_n(rst_n), .msi_req(msi_req), .msi_msg(msi_msg), .delay(delay),
    .msi_ack(msi_ack), .rx_count(rx_count), .rx_msg(rx_msg));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int vec_of(int cat);
    if (eff >= 2) return cat;
    return (eff == 1 && cat == 1) ? 1 : 0;
  endfunction
  function automatic logic [3:0] exist();
    return (eff >= 2) ? 4'hf : (eff == 1) ? 4'h3 : 4'h1;
  endfunction
  function automatic logic [31:0] ctrl(int en, int mme);
    return {7'h0, 1'b1, m_a64[0], mme[2:0], m_mmc[2:0], en[0], 8'h68, 8'h05};
  endfunction
  // Word k: data, mask, status; moves down one word without 64-bit addressing
  function automatic logic [7:0] off(int k);
    return ((m_a64 != 0) ? 8'h54 : 8'h50) + 8'(4 * k);
  endfunction
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK("readdata", e, rd)
  endtask
  task automatic fire(input int j);
    @(posedge clk);
    evt_in <= 7'(1 << j);
    delay <= 4'(xs());
    @(posedge clk);
    evt_in <= '0;
  endtask
  task automatic expect_msg(input int cat);
    for (int k = 0; k < 200 && rx_count == n; k++) @(posedge clk);
    if (rx_count == n) begin
      num_errors++;
      end_sim();
    end
    n = rx_count;
    `CHK("vector", 2'(vec_of(cat)), rx_msg.vector)
    `CHK("data", {16'h0, m_base & ~16'((1 << eff) - 1) | 16'(vec_of(cat))}, rx_msg.data)
    `CHK("addr", {(m_a64 != 0) ? m_hi : 32'h0, m_lo}, rx_msg.addr)
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    cfg_load = 1'b0;
    cfg_in = '{cap_id: 8'h05, next_ptr: 8'h68, mmc: 3'h3, addr64: 1'b1, pvm: 1'b1};
    evt_in = '0;
    cat_clear = 4'h0;
    delay = 4'h0;
    seed = 32'h9;
    m_mmc = 3;
    m_a64 = 1;
    m_mask = 4'h0;
    n = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd(8'h48, ctrl(0, 0));
    chk_rd(8'h58, 32'h0);
    chk_rd(8'h5c, 32'h0);
    chk_rd(8'h60, 32'h0);
    bus(1'b1, 8'h48, 32'hffffffff);
    chk_rd(8'h48, ctrl(1, 7));
    m_lo = xs() & 32'hfffffffc;
    m_hi = xs();
    m_base = 16'(xs());
    bus(1'b1, 8'h4c, m_lo | 32'h3);
    bus(1'b1, 8'h50, m_hi);
    bus(1'b1, 8'h54, {16'hffff, m_base});
    chk_rd(8'h4c, m_lo);
    chk_rd(8'h50, m_hi);
    chk_rd(8'h54, {16'h0, m_base});
    foreach (codes[i]) begin
      bus(1'b1, 8'h48, ctrl(1, codes[i]));
      eff = (codes[i] < m_mmc) ? codes[i] : m_mmc;
      for (int j = 0; j < 7; j++) begin
        fire(j);
        expect_msg(j == 6 ? 0 : j >= 2 ? 1 : j == 1 ? 2 : 3);
      end
      m_mask = m_mask | exist();
      bus(1'b1, off(1), 32'hffffffff);
      chk_rd(off(1), {28'h0, m_mask & exist()});
      fire(1);
      repeat (20) @(posedge clk);
      `CHK("message count", n, rx_count)
      chk_rd(off(2), 32'(1 << vec_of(2)));
      m_mask = m_mask & ~exist();
      bus(1'b1, off(1), 32'h0);
      expect_msg(2);
      chk_rd(off(2), 32'h0);
    end
    bus(1'b1, 8'h48, ctrl(0, 2));
    eff = 2;
    fire(0);
    repeat (3) @(posedge clk);
    `CHK("legacy pin", 1'b0, legacy_interrupt_out_n)
    `CHK("intx enable", 1'b1, intx_enable)
    chk_rd(off(2), 32'h8);
    `CHK("message count", n, rx_count)
    cat_clear <= 4'h8;
    @(posedge clk);
    cat_clear <= 4'h0;
    repeat (3) @(posedge clk);
    `CHK("legacy pin", 1'b1, legacy_interrupt_out_n)
    bus(1'b1, 8'h48, ctrl(1, 2));
    repeat (2) @(posedge clk);
    `CHK("intx enable", 1'b0, intx_enable)
    cfg_in <= '{cap_id: 8'h05, next_ptr: 8'h68, mmc: 3'h2, addr64: 1'b0, pvm: 1'b1};
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    m_mmc = 2;
    m_a64 = 0;
    chk_rd(8'h48, ctrl(1, 2));
    m_base = 16'(xs());
    bus(1'b1, 8'h50, {16'h0, m_base});
    chk_rd(8'h50, {16'h0, m_base});
    chk_rd(8'h5c, 32'h0);
    bus(1'b1, 8'h48, ctrl(1, 3));
    eff = 2;
    fire(3);
    expect_msg(1);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    m_mmc = 3;
    m_a64 = 1;
    n = 0;
    chk_rd(8'h48, ctrl(0, 0));
    end_sim();
  end
endmodule
